// ===== bbi_pkg.sv
// constants and carrier types of the baseband event block
//
// What this block does
// (RQ1) header found event on valid PHY header
// (RQ2) header found loads frame length registers
// (RQ3) frame end event after delay, payload stored
// (RQ4) frame end moves receive to tx prepare
// (RQ5) frame end needs filter pass, address match when filter enabled
// (RQ6) extended match event when filter enabled
// (RQ7) address match event when filter enabled
// (RQ8) match events issued when header parsing ends
// (RQ9) tx frame end when last part sent
// (RQ10) gain hold on preamble detection
// (RQ11) gain hold freezes gain control settings
// (RQ12) gain release on receive finish or cancel
// (RQ13) release during reception aborts and restarts
// (RQ14) gain hold clears pending gain release
// (RQ15) gain release clears pending gain hold
// (RQ16) level event when octet count hits threshold
// (RQ17) threshold from low and high registers
// (RQ18) own status and mask, per event
// (RQ19) checksum filter gates frame end when set
// (RQ20) status bits clear on status read
package bbi_pkg;
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_MASK = 4'h1;
  localparam logic [3:0] ADDR_LEN_LOW = 4'h2;
  localparam logic [3:0] ADDR_LEN_HIGH = 4'h3;
  localparam logic [3:0] ADDR_THR_LOW = 4'h4;
  localparam logic [3:0] ADDR_THR_HIGH = 4'h5;
  localparam logic [3:0] ADDR_CTRL = 4'h6;
  localparam logic [3:0] ADDR_STATE = 4'h7;
  // event bit positions in status and mask
  localparam int EV_HEADER = 0;
  localparam int EV_FRAME_END = 1;
  localparam int EV_EXT_MATCH = 2;
  localparam int EV_ADDR_MATCH = 3;
  localparam int EV_TX_END = 4;
  localparam int EV_HOLD = 5;
  localparam int EV_RELEASE = 6;
  localparam int EV_LEVEL = 7;
  // control register fields
  localparam int CTRL_ADDR_FILTER = 0;
  localparam int CTRL_FCS_FILTER = 1;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h02;
  // frame end delay after frame end
  localparam int FRAME_END_DELAY_NS = 100;
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int FRAME_END_DELAY_CYC =
    (FRAME_END_DELAY_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RECEIVE = 2'b01,
    ST_TX_PREPARE = 2'b10
  } bbi_state_t;
  // strobes from the receive and transmit datapaths
  typedef struct packed {
    logic preamble;
    logic header_ok;
    logic [10:0] header_len;
    logic parse_done;
    logic is_extended;
    logic is_match;
    logic first_pass;
    logic fcs_ok;
    logic frame_done;
    logic rx_finish;
    logic octet_stored;
    logic tx_done;
  } bbi_path_t;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bbi_req_t;
endpackage

// ===== bbi_delay.sv
// fixed delay line for a one-cycle strobe
`timescale 1ns/1ps
module bbi_delay #(
  parameter int DEPTH = 10
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic in_pulse,
  output logic out_pulse
);
  logic [DEPTH-1:0] line_q;
  always_ff @(posedge clock)
  begin
    if (srst)
      line_q <= '0;
    else
      line_q <= {line_q[DEPTH-2:0], in_pulse};
  end
  assign out_pulse = line_q[DEPTH-1];
endmodule

// ===== bbi_level.sv
// receive octet counter with threshold compare
`timescale 1ns/1ps
module bbi_level #(
  parameter int WIDTH = 11
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic restart,
  input wire logic octet,
  input wire logic [WIDTH-1:0] threshold,
  output logic reached
);
  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;
  assign count_d = count_q + WIDTH'(1);
  always_ff @(posedge clock)
  begin
    if (srst || restart)
      count_q <= '0;
    else if (octet)
      count_q <= count_d;
  end
  // (RQ16) level reached pulse
  always_ff @(posedge clock)
  begin
    if (srst)
      reached <= 1'b0;
    else
      reached <= octet && !restart && count_d == threshold;
  end
endmodule

// ===== bbi_events.sv
// baseband event status, mask and receive flow
//
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/1ps
module bbi_events (
  input wire logic clock,
  input wire logic srst,
  input wire bbi_pkg::bbi_req_t req,
  output logic [7:0] rdata,
  input wire bbi_pkg::bbi_path_t path,
  output logic gain_freeze,
  output logic rx_restart,
  output logic [7:0] event_pending,
  output logic [1:0] state
);
  // ***************
  // register decode
  // ***************
  logic [7:0] status_q, mask_q, ctrl_q, len_low_q, len_high_q;
  logic [7:0] thr_low_q, thr_high_q;
  logic [7:0] rdata_q;
  logic freeze_q, restart_q;
  bbi_pkg::bbi_state_t state_q;
  wire wr_mask = req.wr && req.addr == bbi_pkg::ADDR_MASK;
  wire wr_ctrl = req.wr && req.addr == bbi_pkg::ADDR_CTRL;
  wire wr_thr_low = req.wr && req.addr == bbi_pkg::ADDR_THR_LOW;
  wire wr_thr_high = req.wr && req.addr == bbi_pkg::ADDR_THR_HIGH;
  wire rd_status = req.rd && req.addr == bbi_pkg::ADDR_STATUS;
  wire addr_filter = ctrl_q[bbi_pkg::CTRL_ADDR_FILTER];
  wire fcs_filter = ctrl_q[bbi_pkg::CTRL_FCS_FILTER];
  logic [7:0] rd_mux;
  always_comb
  begin
    unique case (req.addr)
      bbi_pkg::ADDR_STATUS: rd_mux = status_q;
      bbi_pkg::ADDR_MASK: rd_mux = mask_q;
      bbi_pkg::ADDR_LEN_LOW: rd_mux = len_low_q;
      bbi_pkg::ADDR_LEN_HIGH: rd_mux = len_high_q;
      bbi_pkg::ADDR_THR_LOW: rd_mux = thr_low_q;
      bbi_pkg::ADDR_THR_HIGH: rd_mux = thr_high_q;
      bbi_pkg::ADDR_CTRL: rd_mux = ctrl_q;
      bbi_pkg::ADDR_STATE: rd_mux = {6'h00, state_q};
      default: rd_mux = 8'h00;
    endcase
  end

  // ***************
  // receive flow
  // ***************
  wire in_rx = state_q == bbi_pkg::ST_RECEIVE;
  // (RQ13) release mid reception aborts
  logic end_late;
  // release in the frame end cycle is a finish, not a cancel
  wire abort = path.rx_finish && in_rx && !end_late;
  // (RQ5) filter and address gating
  wire frame_ok = path.first_pass
    && (!addr_filter || path.is_match)
    // (RQ19) checksum gating
    && (!fcs_filter || path.fcs_ok);
  wire frame_start = path.frame_done && frame_ok && in_rx;
  // (RQ3) frame end after fixed delay
  bbi_delay #(
    .DEPTH(bbi_pkg::FRAME_END_DELAY_CYC)
  ) u_delay (
    .clock(clock),
    .srst(srst || abort),
    .in_pulse(frame_start),
    .out_pulse(end_late)
  );
  logic level_hit;
  bbi_level #(
    .WIDTH(11)
  ) u_level (
    .clock(clock),
    .srst(srst),
    .restart(path.preamble),
    .octet(path.octet_stored),
    // (RQ17) threshold from two registers
    .threshold({thr_high_q[2:0], thr_low_q}),
    .reached(level_hit)
  );
  logic [7:0] ev;
  always_comb
  begin
    ev = 8'h00;
    // (RQ1) header found
    ev[bbi_pkg::EV_HEADER] = path.header_ok && in_rx;
    ev[bbi_pkg::EV_FRAME_END] = end_late;
    // (RQ8) strobed at parse end
    // (RQ6) extended match at parse end
    ev[bbi_pkg::EV_EXT_MATCH] = path.parse_done && addr_filter
      && path.is_extended && in_rx;
    // (RQ7) address match at parse end
    ev[bbi_pkg::EV_ADDR_MATCH] = path.parse_done && addr_filter
      && path.is_match && in_rx;
    // (RQ9) transmit done
    ev[bbi_pkg::EV_TX_END] = path.tx_done;
    // (RQ10) preamble detected
    ev[bbi_pkg::EV_HOLD] = path.preamble;
    // (RQ12) receive finished or cancelled
    ev[bbi_pkg::EV_RELEASE] = path.rx_finish && !path.preamble;
    ev[bbi_pkg::EV_LEVEL] = level_hit;
  end
  // (RQ18) per-event mask
  wire [7:0] ev_en = ev & mask_q;
  logic [7:0] status_d;
  always_comb
  begin
    // (RQ20) read clears, set wins
    status_d = (rd_status ? 8'h00 : status_q) | ev_en;
    // (RQ14) hold clears release
    if (ev_en[bbi_pkg::EV_HOLD])
      status_d[bbi_pkg::EV_RELEASE] = 1'b0;
    // (RQ15) release clears hold
    if (ev_en[bbi_pkg::EV_RELEASE])
      status_d[bbi_pkg::EV_HOLD] = 1'b0;
  end
  bbi_pkg::bbi_state_t state_d;
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      bbi_pkg::ST_IDLE:
        state_d = bbi_pkg::ST_RECEIVE;
      bbi_pkg::ST_RECEIVE:
      begin
        // (RQ4) receive to tx prepare
        if (end_late)
          state_d = bbi_pkg::ST_TX_PREPARE;
      end
      bbi_pkg::ST_TX_PREPARE:
      begin
        if (path.preamble)
          state_d = bbi_pkg::ST_RECEIVE;
      end
      default:
        state_d = bbi_pkg::ST_IDLE;
    endcase
  end

  // ***************
  // registers
  // ***************
  wire [7:0] rd_next = req.rd ? rd_mux : 8'h00;
  // status, read data and state
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      status_q <= 8'h00;
      rdata_q <= 8'h00;
      state_q <= bbi_pkg::ST_IDLE;
    end
    else
    begin
      status_q <= status_d;
      rdata_q <= rd_next;
      state_q <= state_d;
    end
  end
  // mask and control
  always_ff @(posedge clock)
  begin
    if (srst)
      mask_q <= bbi_pkg::MASK_RESET;
    else if (wr_mask)
      mask_q <= req.wdata;
  end
  always_ff @(posedge clock)
  begin
    if (srst)
      ctrl_q <= bbi_pkg::CTRL_RESET;
    else if (wr_ctrl)
      ctrl_q <= req.wdata & 8'h03;
  end
  // threshold pair
  always_ff @(posedge clock)
  begin
    if (srst)
      thr_low_q <= 8'h00;
    else if (wr_thr_low)
      thr_low_q <= req.wdata;
  end
  always_ff @(posedge clock)
  begin
    if (srst)
      thr_high_q <= 8'h00;
    else if (wr_thr_high)
      thr_high_q <= req.wdata & 8'h07;
  end
  // (RQ2) length from valid header
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      len_low_q <= 8'h00;
      len_high_q <= 8'h00;
    end
    else if (ev[bbi_pkg::EV_HEADER])
    begin
      len_low_q <= path.header_len[7:0];
      len_high_q <= {5'h00, path.header_len[10:8]};
    end
  end
  // (RQ11) freeze gain on hold
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      freeze_q <= 1'b0;
      restart_q <= 1'b0;
    end
    else
    begin
      if (path.preamble)
        freeze_q <= 1'b1;
      else if (path.rx_finish)
        freeze_q <= 1'b0;
      restart_q <= abort;
    end
  end
  assign rdata = rdata_q;
  assign gain_freeze = freeze_q;
  assign rx_restart = restart_q;
  assign event_pending = status_q;
  assign state = state_q;

  // ***************
  // checks
  // ***************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);
  // (RQ14) hold clears release
  a_hold_clears_rel: assert property ( // RQ14
    ev_en[bbi_pkg::EV_HOLD] |=> !status_q[bbi_pkg::EV_RELEASE])
    else $error("release stays after hold");
  // (RQ15) release clears hold
  a_rel_clears_hold: assert property ( // RQ15
    ev_en[bbi_pkg::EV_RELEASE] |=> !status_q[bbi_pkg::EV_HOLD])
    else $error("hold stays after release");
  // (RQ4) frame end to tx prepare
  a_end_to_prep: assert property ( // RQ4
    end_late |=> state_q == bbi_pkg::ST_TX_PREPARE)
    else $error("no tx prepare after frame end");
  // (RQ20) read clears status
  a_read_clears: assert property ( // RQ20
    rd_status && ev_en == 8'h00 |=> status_q == 8'h00)
    else $error("status not cleared by read");
  // (RQ18) enabled event latches
  a_masked_event: assert property ( // RQ18
    ev_en[bbi_pkg::EV_TX_END] |=> status_q[bbi_pkg::EV_TX_END])
    else $error("tx end not latched");
  // (RQ2) low length byte
  a_header_len: assert property ( // RQ2
    ev[bbi_pkg::EV_HEADER] |=> len_low_q == $past(path.header_len[7:0]))
    else $error("length not loaded");
  // (RQ11) gain frozen on hold
  a_freeze_hold: assert property ( // RQ11
    path.preamble |=> gain_freeze)
    else $error("gain not frozen");
  // (RQ13) abort restarts receive
  a_abort_restart: assert property ( // RQ13
    abort |=> rx_restart && state_q == bbi_pkg::ST_RECEIVE)
    else $error("no restart on abort");
  // (RQ1) header event latches
  a_header_status: assert property ( // RQ1
    ev_en[bbi_pkg::EV_HEADER] |=> status_q[bbi_pkg::EV_HEADER])
    else $error("header event not latched");
  // (RQ2) high length bits
  a_len_high: assert property ( // RQ2
    ev[bbi_pkg::EV_HEADER]
    |=> len_high_q == {5'h00, $past(path.header_len[10:8])})
    else $error("high length not loaded");
  // (RQ3) fixed lag after frame end
  a_end_delay: assert property ( // RQ3
    end_late |-> $past(frame_start, bbi_pkg::FRAME_END_DELAY_CYC))
    else $error("frame end without earlier frame");
  // (RQ5) first filter level passed
  a_end_filtered: assert property ( // RQ5
    end_late |-> $past(path.first_pass, bbi_pkg::FRAME_END_DELAY_CYC))
    else $error("frame end after failed filter");
  // (RQ19) checksum gate
  a_fcs_gate: assert property ( // RQ19
    end_late && $past(fcs_filter, bbi_pkg::FRAME_END_DELAY_CYC)
    |-> $past(path.fcs_ok, bbi_pkg::FRAME_END_DELAY_CYC))
    else $error("frame end with bad checksum");
  // (RQ6) extended match latches
  a_ext_match: assert property ( // RQ6
    path.parse_done && addr_filter && path.is_extended && in_rx
    && mask_q[bbi_pkg::EV_EXT_MATCH] |=> status_q[bbi_pkg::EV_EXT_MATCH])
    else $error("extended match not latched");
  // (RQ7) address match latches
  a_addr_match: assert property ( // RQ7
    path.parse_done && addr_filter && path.is_match && in_rx
    && mask_q[bbi_pkg::EV_ADDR_MATCH] |=> status_q[bbi_pkg::EV_ADDR_MATCH])
    else $error("address match not latched");
  // (RQ8) match only at parse end
  a_parse_only: assert property ( // RQ8
    ev[bbi_pkg::EV_EXT_MATCH] || ev[bbi_pkg::EV_ADDR_MATCH] |-> path.parse_done)
    else $error("match event outside parse end");
  // (RQ9) transmit end latches
  a_tx_end: assert property ( // RQ9
    path.tx_done && mask_q[bbi_pkg::EV_TX_END] |=> status_q[bbi_pkg::EV_TX_END])
    else $error("tx end event lost");
  // (RQ10) hold on preamble
  a_hold_event: assert property ( // RQ10
    path.preamble && mask_q[bbi_pkg::EV_HOLD] |=> status_q[bbi_pkg::EV_HOLD])
    else $error("hold event lost");
  // (RQ12) release frees gain
  a_release_free: assert property ( // RQ12
    path.rx_finish && !path.preamble |=> !gain_freeze)
    else $error("gain not released");
  // (RQ16) level event latches
  a_level_event: assert property ( // RQ16
    level_hit && mask_q[bbi_pkg::EV_LEVEL] |=> status_q[bbi_pkg::EV_LEVEL])
    else $error("level event lost");
  // (RQ18) all masked, status kept
  a_unmasked: assert property ( // RQ18
    mask_q == 8'h00 && !rd_status |=> status_q == $past(status_q))
    else $error("masked event changed status");
  // (RQ4) idle enters receive
  a_idle_leaves: assert property ( // RQ4
    state_q == bbi_pkg::ST_IDLE |=> state_q == bbi_pkg::ST_RECEIVE)
    else $error("idle not left");
endmodule

// ===== bbi_path_model.sv
// model of the receive and transmit datapaths feeding the event block
`timescale 1ns/1ps
module bbi_path_model (
  input wire logic clock,
  output bbi_pkg::bbi_path_t path
);
  initial path = '0;
  // kind: 6 preamble,5 header,4 parse,3 frame,2 finish,1 octet,0 tx
  // lv: {is_extended, is_match, first_pass, fcs_ok}
  task automatic send(input int kind, input logic [10:0] len,
                      input logic [3:0] lv);
    @(posedge clock);
    {path.preamble, path.header_ok, path.parse_done, path.frame_done,
     path.rx_finish, path.octet_stored, path.tx_done} <= 7'h01 << kind;
    path.header_len <= len;
    {path.is_extended, path.is_match, path.first_pass, path.fcs_ok} <= lv;
    @(posedge clock);
    {path.preamble, path.header_ok, path.parse_done, path.frame_done,
     path.rx_finish, path.octet_stored, path.tx_done} <= 7'h00;
    // qualifiers no longer valid: show the inverse
    path.header_len <= ~len;
    {path.is_extended, path.is_match, path.first_pass, path.fcs_ok} <= ~lv;
  endtask
endmodule

// ===== test_bbi_events.sv
// self-checking testbench of the baseband event block
`timescale 1ns/1ps
module test_bbi_events;
  logic clock;
  logic srst;
  bbi_pkg::bbi_req_t req;
  bbi_pkg::bbi_path_t path;
  logic [7:0] rdata;
  logic gain_freeze;
  logic rx_restart;
  logic [7:0] event_pending;
  logic [1:0] state;
  int failures = 0;
  int checked = 0;
  int restarts = 0;
  int n;
  logic [7:0] ctl [3] = '{8'h02, 8'h00, 8'h01};
  logic [3:0] lvl [3] = '{4'h2, 4'h1, 4'h3};

  bbi_events u_bbi_events (.clock(clock), .srst(srst), .req(req),
    .rdata(rdata), .path(path), .gain_freeze(gain_freeze),
    .rx_restart(rx_restart), .event_pending(event_pending), .state(state));
  bbi_path_model u_bbi_path_model (.clock(clock), .path(path));

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  always @(posedge clock)
    if (rx_restart === 1'b1)
      restarts <= restarts + 1;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clock);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    req.rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  task automatic conclude;
    if (failures == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    srst = 1'b1;
    req = '0;
    repeat (12) @(posedge clock);
    srst <= 1'b0;
    rd(bbi_pkg::ADDR_MASK, bbi_pkg::MASK_RESET);
    rd(bbi_pkg::ADDR_CTRL, bbi_pkg::CTRL_RESET);
    rd(bbi_pkg::ADDR_STATE, 8'h01);
    wr(4'h9, 8'hFF);
    rd(4'h9, 8'h00);
    wr(bbi_pkg::ADDR_MASK, 8'hFF);
    rd(bbi_pkg::ADDR_MASK, 8'hFF);
    u_bbi_path_model.send(5, 11'h5A3, 4'h0);
    rd(bbi_pkg::ADDR_STATUS, 8'h01);
    rd(bbi_pkg::ADDR_LEN_LOW, 8'hA3);
    rd(bbi_pkg::ADDR_LEN_HIGH, 8'h05);
    rd(bbi_pkg::ADDR_STATUS, 8'h00);
    wr(bbi_pkg::ADDR_CTRL, 8'h03);
    u_bbi_path_model.send(4, 11'h000, 4'hC);
    rd(bbi_pkg::ADDR_STATUS, 8'h0C);
    u_bbi_path_model.send(4, 11'h000, 4'h8);
    rd(bbi_pkg::ADDR_STATUS, 8'h04);
    wr(bbi_pkg::ADDR_CTRL, 8'h02);
    u_bbi_path_model.send(4, 11'h000, 4'hC);
    rd(bbi_pkg::ADDR_STATUS, 8'h00);
    u_bbi_path_model.send(2, 11'h000, 4'h0);
    repeat (3) @(posedge clock);
    chk(8'(restarts), 8'h01);
    u_bbi_path_model.send(6, 11'h000, 4'h0);
    rd(bbi_pkg::ADDR_STATUS, 8'h20);
    chk({7'h00, gain_freeze}, 8'h01);
    u_bbi_path_model.send(2, 11'h000, 4'h0);
    rd(bbi_pkg::ADDR_STATUS, 8'h40);
    chk({7'h00, gain_freeze}, 8'h00);
    wr(bbi_pkg::ADDR_THR_LOW, 8'h02);
    wr(bbi_pkg::ADDR_THR_HIGH, 8'h01);
    u_bbi_path_model.send(6, 11'h000, 4'h0);
    rd(bbi_pkg::ADDR_STATUS, 8'h20);
    repeat (257) u_bbi_path_model.send(1, 11'h000, 4'h0);
    rd(bbi_pkg::ADDR_STATUS, 8'h00);
    u_bbi_path_model.send(1, 11'h000, 4'h0);
    rd(bbi_pkg::ADDR_STATUS, 8'h80);
    for (int i = 0; i < 3; i++)
    begin
      wr(bbi_pkg::ADDR_CTRL, ctl[i]);
      u_bbi_path_model.send(3, 11'h000, lvl[i]);
      repeat (15) @(posedge clock);
      rd(bbi_pkg::ADDR_STATUS, 8'h00);
    end
    wr(bbi_pkg::ADDR_CTRL, 8'h00);
    u_bbi_path_model.send(3, 11'h000, 4'h2);
    for (n = 0; n < 40 && event_pending[1] !== 1'b1; n++)
    begin
      @(posedge clock);
      #1;
    end
    if (n == 40)
    begin
      failures++;
      conclude();
    end
    chk({7'h00, n == bbi_pkg::FRAME_END_DELAY_CYC}, 8'h01);
    chk(event_pending, 8'h02);
    rd(bbi_pkg::ADDR_STATUS, 8'h02);
    rd(bbi_pkg::ADDR_STATE, 8'h02);
    chk({6'h00, state}, 8'h02);
    u_bbi_path_model.send(0, 11'h000, 4'h0);
    rd(bbi_pkg::ADDR_STATUS, 8'h10);
    wr(bbi_pkg::ADDR_MASK, 8'hEF);
    u_bbi_path_model.send(0, 11'h000, 4'h0);
    rd(bbi_pkg::ADDR_STATUS, 8'h00);
    conclude();
  end
endmodule
